// ### pcg_params.svh
`ifndef PCG_PARAMS_SVH
`define PCG_PARAMS_SVH

// Register byte offsets on the APB slave, one aligned 32-bit word each.
`define PCG_OFF_CTRL 12'h000
`define PCG_OFF_CFG 12'h004
`define PCG_OFF_POLY_LO 12'h008
`define PCG_OFF_POLY_HI 12'h00c
`define PCG_OFF_DATA_LO 12'h010
`define PCG_OFF_DATA_HI 12'h014
`define PCG_OFF_RES_LO 12'h018
`define PCG_OFF_RES_HI 12'h01c

// Bit positions inside control_status_one.
`define PCG_CS_ON 15
`define PCG_CS_IDLE 13
`define PCG_CS_CNT_LSB 8
`define PCG_CS_FULL 7
`define PCG_CS_EMPTY 6
`define PCG_CS_ISEL 5
`define PCG_CS_RUN 4
`define PCG_CS_LSB 3

// Field positions inside width_length_config.
`define PCG_CFG_DW_LSB 8
`define PCG_CFG_PL_LSB 0

// Word counts that the FIFO admits for each class of data width.
`define PCG_DEPTH_WIDE 5'h04
`define PCG_DEPTH_MID 5'h08
`define PCG_DEPTH_NARROW 5'h10

// Width field thresholds that select the FIFO depth and the byte lanes.
`define PCG_DW_MID_MIN 5'h08
`define PCG_DW_WIDE_MIN 5'h10

// Reset values of the configuration state.
`define PCG_CFG_RESET 5'h00
`define PCG_POLY_RESET 32'h00000000
`define PCG_RESULT_RESET 32'h00000000

`endif

// ### pcg_pkg.sv
package pcg_pkg;

  // Engine sequence, Gray coded along idle, load, shift, drain.
  typedef enum logic [1:0] {
    pcg_st_idle = 2'b00,
    pcg_st_load = 2'b01,
    pcg_st_shift = 2'b11,
    pcg_st_drain = 2'b10
  } pcg_state_t;

  // Decoded register selected by an APB address.
  typedef enum logic [3:0] {
    pcg_reg_none = 4'h0,
    pcg_reg_ctrl = 4'h1,
    pcg_reg_cfg = 4'h2,
    pcg_reg_poly_lo = 4'h3,
    pcg_reg_poly_hi = 4'h4,
    pcg_reg_data_lo = 4'h5,
    pcg_reg_data_hi = 4'h6,
    pcg_reg_res_lo = 4'h7,
    pcg_reg_res_hi = 4'h8
  } pcg_reg_t;

endpackage

// ### pcg_fifo_mem.sv
`timescale 1ns/1ps
module pcg_fifo_mem #(
  parameter int WORD_W = 32,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Write side.
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WORD_W-1:0] wr_data,
  // Read side; data appear one edge after the read enable.
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WORD_W-1:0] rd_data
);

  // Depths below two, or not a power of two, are refused.
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("pcg_fifo_mem: DEPTH must be a power of two of at least two");
  end

  // The whole state: the word array and the registered read port.
  typedef struct packed {
    logic [DEPTH-1:0][WORD_W-1:0] mem;
    logic [WORD_W-1:0] rdata;
  } pcg_mem_state_t;

  pcg_mem_state_t r;
  pcg_mem_state_t next_r;

  // A read of the slot being written returns the old word; the owner never pops an unwritten slot.
  always_comb begin
    next_r = r;
    if (wr_en) begin
      next_r.mem[wr_addr] = wr_data;
    end
    if (rd_en) begin
      next_r.rdata = r.mem[rd_addr];
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rd_data = r.rdata;

endmodule

// ### pcg_shift_engine.sv
`timescale 1ns/1ps
module pcg_shift_engine (
  // Current remainder and polynomial setup.
  input wire logic [31:0] crc_in,
  input wire logic [31:0] poly,
  input wire logic [4:0] poly_len,
  // Data bits in the order they enter, and whether the second one is used.
  input wire logic bit_a,
  input wire logic bit_b,
  input wire logic two_bits,
  // Remainder after one or two steps.
  output logic [31:0] crc_out
);

  // One Galois step; the register is cut to the programmed length.
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic din,
                                           input logic [31:0] p, input logic [4:0] len);
    logic fb;
    logic [31:0] nx;
    fb = din ^ c[len];
    nx = '0;
    nx[0] = fb;
    for (int i = 1; i < 32; i++) begin
      if (5'(i) <= len) begin
        nx[i] = c[i-1] ^ (p[i] & fb);
      end
    end
    return nx;
  endfunction

  logic [31:0] after_a;

  // Two bits per cycle; an odd final bit takes one step only.
  always_comb begin
    after_a = crc_step(crc_in, bit_a, poly, poly_len);
    crc_out = two_bits ? crc_step(after_a, bit_b, poly, poly_len) : after_a;
  end

endmodule

// ### pcg_top.sv
`timescale 1ns/1ps
`include "pcg_params.svh"
// How it works
// - Length field holds order minus one.
// - Constant term always fed back.
// - Term enable bit inserts an XOR.
// - Top order term is always implied.
// - Width field holds word width minus one.
// - FIFO depth four, eight or sixteen.
// - Byte-wide writes; bits above width ignored.
// - Count rises on write covering MSb.
// - Engine starts with run and words waiting.
// - Word moves to buffer, two bits per cycle.
// - Full at depth, empty at zero.
// - Module off clears FIFO and engine state.
// - MSb or LSb first; result unreflected.
// - Event on last pop or completion.
// - Software clearing run gives no event.
// - Completion follows (length+1)/2 cycles later.
// - Hardware clears run when finished.
// - Idle halt bit stops engine in idle.
module pcg_top #(
  parameter int FIFO_WORDS = 16,
  parameter int ADDR_W = 12
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // System idle request, asynchronous to pclk.
  input wire logic idle_req,
  // One-cycle event toward the system interrupt controller.
  output logic crc_event
);
  import pcg_pkg::*;

  localparam int PTR_W = $clog2(FIFO_WORDS);

  // The narrow data class needs sixteen slots; the decoder needs the full offset range.
  if (FIFO_WORDS < 16 || (1 << PTR_W) != FIFO_WORDS) begin : g_bad_fifo
    $error("pcg_top: FIFO_WORDS must be a power of two of at least 16");
  end
  if (ADDR_W < 5) begin : g_bad_addr
    $error("pcg_top: ADDR_W must be at least 5");
  end

  // All state of the block outside the FIFO memory in one record.
  typedef struct packed {
    logic on;                   // Module enable.
    logic idle_sel;             // Halt while the system idles.
    logic isel;                 // Event source select.
    logic run;                  // Engine run bit.
    logic lsb_first;            // Shift direction.
    logic [4:0] data_width;     // Data width minus one.
    logic [4:0] poly_len;       // Polynomial length minus one.
    logic [31:0] poly;          // Term enables; bit zero stays clear.
    logic [31:0] stage;         // Input staging word, both halves.
    logic [PTR_W:0] count;      // Words waiting in the FIFO.
    logic [PTR_W-1:0] wr_ptr;   // FIFO write slot.
    logic [PTR_W-1:0] rd_ptr;   // FIFO read slot.
    pcg_state_t state;          // Engine sequence.
    logic [31:0] shbuf;         // Word being shifted.
    logic [5:0] bits_left;      // Bits still to shift from the buffer.
    logic [4:0] drain;          // Cycles left before completion.
    logic [31:0] crc;           // Result pair.
    logic [31:0] prdata;        // Read data held for the access phase.
    logic pslverr;              // Error answer held for the access phase.
    logic event_pulse;          // Event output.
    logic idle_s1;              // Idle synchroniser, first stage.
    logic idle_s2;              // Idle synchroniser, second stage.
  } pcg_regs_t;

  pcg_regs_t r;
  pcg_regs_t next_r;

  // Wires between the record and the two helper modules.
  logic mem_we;
  logic mem_re;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rdata;
  logic eng_a;
  logic eng_b;
  logic eng_two;
  logic [31:0] eng_crc;

  // Address decode, shared by the read and the write path.
  function automatic pcg_reg_t reg_decode(input logic [ADDR_W-1:0] a);
    pcg_reg_t s;
    s = pcg_reg_none;
    case (a)
      ADDR_W'(`PCG_OFF_CTRL): s = pcg_reg_ctrl;
      ADDR_W'(`PCG_OFF_CFG): s = pcg_reg_cfg;
      ADDR_W'(`PCG_OFF_POLY_LO): s = pcg_reg_poly_lo;
      ADDR_W'(`PCG_OFF_POLY_HI): s = pcg_reg_poly_hi;
      ADDR_W'(`PCG_OFF_DATA_LO): s = pcg_reg_data_lo;
      ADDR_W'(`PCG_OFF_DATA_HI): s = pcg_reg_data_hi;
      ADDR_W'(`PCG_OFF_RES_LO): s = pcg_reg_res_lo;
      ADDR_W'(`PCG_OFF_RES_HI): s = pcg_reg_res_hi;
      default: s = pcg_reg_none;
    endcase
    return s;
  endfunction

  // Words the FIFO admits for a given width field.
  function automatic logic [PTR_W:0] depth_for(input logic [4:0] dw);
    logic [PTR_W:0] d;
    if (dw >= `PCG_DW_WIDE_MIN) begin
      d = (PTR_W+1)'(`PCG_DEPTH_WIDE);
    end else if (dw >= `PCG_DW_MID_MIN) begin
      d = (PTR_W+1)'(`PCG_DEPTH_MID);
    end else begin
      d = (PTR_W+1)'(`PCG_DEPTH_NARROW);
    end
    return d;
  endfunction

  // Ones in every bit up to and including the width field's MSb.
  function automatic logic [31:0] width_mask(input logic [4:0] dw);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 32; i++) begin
      m[i] = (5'(i) <= dw);
    end
    return m;
  endfunction

  // Word storage with a registered read port.
  pcg_fifo_mem #(
    .WORD_W(32),
    .DEPTH(FIFO_WORDS),
    .AW(PTR_W)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(mem_we),
    .wr_addr(r.wr_ptr),
    .wr_data(mem_wdata),
    .rd_en(mem_re),
    .rd_addr(r.rd_ptr),
    .rd_data(mem_rdata)
  );

  // Feedback network for one or two data bits.
  pcg_shift_engine u_engine (
    .crc_in(r.crc),
    .poly(r.poly),
    .poly_len(r.poly_len),
    .bit_a(eng_a),
    .bit_b(eng_b),
    .two_bits(eng_two),
    .crc_out(eng_crc)
  );

  // Data bits enter from the top of the word or from bit zero; the
  // remainder itself is never reflected, so the result stays a normal one.
  always_comb begin
    if (r.lsb_first) begin
      eng_a = r.shbuf[0];
      eng_b = r.shbuf[1];
    end else begin
      eng_a = r.shbuf[r.data_width];
      eng_b = r.shbuf[r.data_width - 5'h01];
    end
    eng_two = (r.bits_left >= 6'h02);
  end

  // Next-state logic: engine, APB read and write, then the module-off clear.
  always_comb begin
    logic active;
    logic wr_acc;
    logic push;
    logic pop;
    logic full;
    logic [5:0] step;
    logic [31:0] merged;
    pcg_reg_t rsel;
    active = 1'b0;
    wr_acc = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    full = 1'b0;
    step = 6'h00;
    merged = '0;
    rsel = pcg_reg_none;
    next_r = r;
    mem_we = 1'b0;
    mem_re = 1'b0;
    next_r.event_pulse = 1'b0;

    // The idle request is a pin, so it is resynchronised first.
    next_r.idle_s1 = idle_req;
    next_r.idle_s2 = r.idle_s1;
    active = r.on && !(r.idle_sel && r.idle_s2);

    rsel = reg_decode(paddr);
    wr_acc = psel && penable && pwrite;
    full = (r.count == depth_for(r.data_width));

    // Engine sequence; fetch, shift and drain wait while inactive or while run is low, load does not.
    case (r.state)
      pcg_st_idle: begin
        // Fetch the oldest word only when one is waiting.
        if (active && r.run && r.count != '0) begin
          mem_re = 1'b1;
          pop = 1'b1;
          next_r.rd_ptr = r.rd_ptr + 1'b1;
          next_r.state = pcg_st_load;
          // A pop while the count is one is the early event source.
          if (r.count == (PTR_W+1)'(1) && !r.isel) begin
            next_r.event_pulse = 1'b1;
          end
        end
      end
      pcg_st_load: begin
        // The memory word is valid now; bits above the width are dropped.
        next_r.shbuf = mem_rdata & width_mask(r.data_width);
        next_r.bits_left = {1'b0, r.data_width} + 6'h01;
        next_r.state = pcg_st_shift;
      end
      pcg_st_shift: begin
        if (active && r.run) begin
          step = eng_two ? 6'h02 : 6'h01;
          next_r.crc = eng_crc;
          if (r.lsb_first) begin
            next_r.shbuf = r.shbuf >> step;
          end else begin
            next_r.shbuf = r.shbuf << step;
          end
          next_r.bits_left = r.bits_left - step;
          // Word finished: take the next one, or run out the tail.
          if (r.bits_left <= 6'h02) begin
            if (r.count != '0) begin
              next_r.state = pcg_st_idle;
            end else begin
              next_r.drain = 5'(({1'b0, r.poly_len} + 6'h01) >> 1);
              next_r.state = pcg_st_drain;
            end
          end
        end
      end
      pcg_st_drain: begin
        // A word may still arrive during the tail; it waits in the FIFO until run is set again.
        if (active && r.run) begin
          if (r.drain == 5'h00) begin
            next_r.run = 1'b0;
            next_r.state = pcg_st_idle;
            if (r.isel) begin
              next_r.event_pulse = 1'b1;
            end
          end else begin
            next_r.drain = r.drain - 5'h01;
          end
        end
      end
      default: begin
        next_r.state = pcg_st_idle;
      end
    endcase

    // Read data are captured in the setup phase, so no wait state is needed.
    if (psel && !penable) begin
      next_r.pslverr = (rsel == pcg_reg_none);
      next_r.prdata = '0;
      case (rsel)
        pcg_reg_ctrl: begin
          next_r.prdata[`PCG_CS_ON] = r.on;
          next_r.prdata[`PCG_CS_IDLE] = r.idle_sel;
          next_r.prdata[`PCG_CS_CNT_LSB +: 5] = 5'(r.count);
          next_r.prdata[`PCG_CS_FULL] = full;
          next_r.prdata[`PCG_CS_EMPTY] = (r.count == '0);
          next_r.prdata[`PCG_CS_ISEL] = r.isel;
          next_r.prdata[`PCG_CS_RUN] = r.run;
          next_r.prdata[`PCG_CS_LSB] = r.lsb_first;
        end
        pcg_reg_cfg: begin
          next_r.prdata[`PCG_CFG_DW_LSB +: 5] = r.data_width;
          next_r.prdata[`PCG_CFG_PL_LSB +: 5] = r.poly_len;
        end
        pcg_reg_poly_lo: next_r.prdata[15:0] = r.poly[15:0];
        pcg_reg_poly_hi: next_r.prdata[15:0] = r.poly[31:16];
        pcg_reg_data_lo: next_r.prdata[15:0] = r.stage[15:0];
        pcg_reg_data_hi: next_r.prdata[15:0] = r.stage[31:16];
        pcg_reg_res_lo: next_r.prdata[15:0] = r.crc[15:0];
        pcg_reg_res_hi: next_r.prdata[15:0] = r.crc[31:16];
        default: next_r.prdata = '0;
      endcase
    end

    // Writes take effect in the access phase; they come after the engine,
    // so a software set of run beats a hardware clear in the same cycle.
    if (wr_acc) begin
      case (rsel)
        pcg_reg_ctrl: begin
          if (pstrb[1]) begin
            next_r.on = pwdata[`PCG_CS_ON];
            next_r.idle_sel = pwdata[`PCG_CS_IDLE];
          end
          if (pstrb[0]) begin
            next_r.isel = pwdata[`PCG_CS_ISEL];
            next_r.run = pwdata[`PCG_CS_RUN];
            next_r.lsb_first = pwdata[`PCG_CS_LSB];
          end
        end
        pcg_reg_cfg: begin
          if (pstrb[1]) begin
            next_r.data_width = pwdata[`PCG_CFG_DW_LSB +: 5];
          end
          if (pstrb[0]) begin
            next_r.poly_len = pwdata[`PCG_CFG_PL_LSB +: 5];
          end
        end
        pcg_reg_poly_lo: begin
          // Bit zero is not stored: the constant term is always used.
          if (pstrb[1]) begin
            next_r.poly[15:8] = pwdata[15:8];
          end
          if (pstrb[0]) begin
            next_r.poly[7:1] = pwdata[7:1];
          end
        end
        pcg_reg_poly_hi: begin
          if (pstrb[1]) begin
            next_r.poly[31:24] = pwdata[15:8];
          end
          if (pstrb[0]) begin
            next_r.poly[23:16] = pwdata[7:0];
          end
        end
        pcg_reg_data_lo: begin
          for (int b = 0; b < 2; b++) begin
            if (pstrb[b]) begin
              next_r.stage[b*8 +: 8] = pwdata[b*8 +: 8];
            end
          end
          // Widths up to sixteen complete in the low half.
          push = (r.data_width < `PCG_DW_WIDE_MIN) && pstrb[r.data_width[3]];
        end
        pcg_reg_data_hi: begin
          for (int b = 0; b < 2; b++) begin
            if (pstrb[b]) begin
              next_r.stage[16 + b*8 +: 8] = pwdata[b*8 +: 8];
            end
          end
          // The low half must already be staged when the high half completes.
          // The high half arrives on the low byte lanes, so its MSb lane is bit 3 of the width field.
          push = (r.data_width >= `PCG_DW_WIDE_MIN) && pstrb[r.data_width[3]];
        end
        pcg_reg_res_lo: begin
          next_r.crc[15:0] = pwdata[15:0];
        end
        pcg_reg_res_hi: begin
          next_r.crc[31:16] = pwdata[15:0];
        end
        default: begin
          next_r.pslverr = r.pslverr;
        end
      endcase
    end

    // A word arriving at a full FIFO or a disabled module is dropped.
    push = push && r.on && !full;
    merged = next_r.stage & width_mask(r.data_width);
    mem_wdata = merged;
    if (push) begin
      mem_we = 1'b1;
      next_r.wr_ptr = r.wr_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_r.count = r.count + 1'b1;
    end else if (pop && !push) begin
      next_r.count = r.count - 1'b1;
    end

    // Turning the module off empties the FIFO and restarts the engine,
    // but leaves configuration and the run bit alone.
    if (!next_r.on) begin
      next_r.count = '0;
      next_r.wr_ptr = '0;
      next_r.rd_ptr = '0;
      next_r.state = pcg_st_idle;
      next_r.bits_left = 6'h00;
      next_r.drain = 5'h00;
      next_r.crc = `PCG_RESULT_RESET;
      next_r.stage[31:16] = 16'h0000;
      mem_we = 1'b0;
    end
  end

  // State register; every field starts from zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // The slave never inserts wait states.
  assign pready = 1'b1;
  assign prdata = r.prdata;
  assign pslverr = r.pslverr;
  assign crc_event = r.event_pulse;

endmodule

// ### pcg_top_chk.sv
`timescale 1ns/1ps
`include "pcg_params.svh"
// Port watcher for the CRC block; it sees the APB answer side and the event line.
module pcg_top_chk #(
  parameter int ADDR_W = 12
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Event line.
  input wire logic crc_event
);
  // Read setup phases, decoded per register; read data lands one edge later.
  wire rd_set = psel && !penable && !pwrite;
  wire rd_ctrl = rd_set && (paddr == `PCG_OFF_CTRL);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (psel && !penable && paddr >= 'h20 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && !penable && paddr <= 'h1c && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access refused");
  a_answer_stands: assert property (psel && penable |=> $stable(prdata) && $stable(pslverr))
    else $error("read answer moved before next setup");
  a_ctrl_unused: assert property (rd_ctrl |=> prdata[31:16] == 16'h0 && !prdata[14] && prdata[2:0] == 3'h0)
    else $error("unused control bits set");
  a_count_bound: assert property (rd_ctrl |=> prdata[12:8] <= 5'h10)
    else $error("word count above depth");
  a_full_depth: assert property (rd_ctrl ##1 prdata[7] |-> prdata[12:8] inside {5'h4, 5'h8, 5'h10})
    else $error("full flag at odd count");
  a_empty_zero: assert property (rd_ctrl |=> prdata[6] == (prdata[12:8] == 5'h0))
    else $error("empty flag wrong");
  a_cfg_unused: assert property (rd_set && paddr == `PCG_OFF_CFG |=> prdata[15:13] == 3'h0 && prdata[7:5] == 3'h0)
    else $error("unused config bits set");
  a_term_zero: assert property (rd_set && paddr == `PCG_OFF_POLY_LO |=> !prdata[0])
    else $error("constant term bit readable");
  a_event_pulse: assert property (crc_event |=> !crc_event)
    else $error("event longer than one cycle");
endmodule
bind pcg_top pcg_top_chk #(.ADDR_W(ADDR_W)) pcg_top_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .crc_event(crc_event));

// ### pcg_top_tb_top.sv
`timescale 1ns/1ps
`include "pcg_params.svh"
// Self-checking bench: APB master tasks, a bit-serial reference and one task per scenario.
module pcg_top_tb_top;
  import pcg_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, idle_req = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, crc_event, rerr;
  logic [31:0] prdata, rdv;
  int err_total = 0, comparisons = 0, ev_cnt = 0;
  always #2 pclk = ~pclk;
  // Events are counted here so that no pulse is missed while a task is busy on the bus.
  always @(posedge pclk) if (crc_event === 1'b1) ev_cnt <= ev_cnt + 1;
  pcg_top pcg_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .idle_req(idle_req), .crc_event(crc_event));
  task automatic complete_run;
    $display("Mismatches %0d, comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; the request is held until pready is seen at an edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      err_total++;
      complete_run();
    end
    rdv = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Polls until the engine drops the run bit; a bounded wait.
  task automatic wait_done;
    int k;
    for (k = 0; k < 200; k++) begin
      apb(0, `PCG_OFF_CTRL, 0);
      if (rdv[4] === 1'b0) break;
    end
    if (k == 200) begin
      err_total++;
      complete_run();
    end
  endtask
  // Galois register of length pl+1, feedback from the top bit, constant term forced.
  function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] d, input logic [31:0] poly,
                                           input logic [4:0] pl, input logic [4:0] dw, input logic lsb);
    logic b, fb;
    logic [31:0] m;
    m = (pl == 5'h1f) ? 32'hffffffff : ((32'h1 << ({27'h0, pl} + 1)) - 1);
    for (int i = 0; i <= dw; i++) begin
      b = lsb ? d[i] : d[dw - i];
      fb = b ^ c[pl];
      c = ((c << 1) ^ (fb ? (poly | 32'h1) : 32'h0)) & m;
    end
    return c;
  endfunction
  // Full flow: configure, preload n words, start, wait, compare event count and result.
  task automatic run_crc(input logic [4:0] pl, input logic [4:0] dw, input logic [31:0] poly, input logic lsb,
                         input logic isel, input int n, input logic [31:0] d0, input logic [31:0] dstep);
    int dep, k, ev0;
    logic [31:0] w, exp;
    dep = (dw >= 5'h10) ? 4 : (dw >= 5'h08) ? 8 : 16;
    exp = 32'h0;
    apb(1, `PCG_OFF_CTRL, 32'h8000);
    apb(1, `PCG_OFF_CFG, {19'h0, dw, 3'h0, pl});
    apb(1, `PCG_OFF_POLY_LO, {16'h0, poly[15:0]});
    apb(1, `PCG_OFF_POLY_HI, {16'h0, poly[31:16]});
    apb(1, `PCG_OFF_RES_LO, 0);
    apb(1, `PCG_OFF_RES_HI, 0);
    for (k = 0; k < n; k++) begin
      w = d0 + k * dstep;
      if (k < dep) exp = crc_word(exp, w, poly, pl, dw, lsb);
      apb(1, `PCG_OFF_DATA_LO, {16'h0, w[15:0]});
      if (dw >= 5'h10) begin
        apb(0, `PCG_OFF_CTRL, 0);
        chk("count after low half", rdv[12:8], (k < dep) ? k : dep);
        apb(1, `PCG_OFF_DATA_HI, {16'h0, w[31:16]});
      end
    end
    k = (n < dep) ? n : dep;
    apb(0, `PCG_OFF_CTRL, 0);
    chk("fill level and flags", rdv[12:6], k * 4 + ((k == dep) ? 2 : 0) + ((k == 0) ? 1 : 0));
    ev0 = ev_cnt;
    apb(1, `PCG_OFF_CTRL, {16'h0, 1'b1, 9'h0, isel, 1'b1, lsb, 3'h0});
    wait_done();
    chk("event count", ev_cnt - ev0, 1);
    apb(0, `PCG_OFF_RES_LO, 0);
    w = rdv;
    apb(0, `PCG_OFF_RES_HI, 0);
    chk("result", {rdv[15:0], w[15:0]}, exp);
  endtask
  task automatic s_reset;
    apb(0, `PCG_OFF_CTRL, 0);
    chk("control after reset", rdv, 32'h40);
    apb(0, `PCG_OFF_CFG, 0);
    chk("config after reset", rdv, 0);
    apb(1, `PCG_OFF_POLY_LO, 32'hffff);
    apb(0, `PCG_OFF_POLY_LO, 0);
    chk("term bit zero", rdv, 32'hfffe);
    apb(0, 12'h020, 0);
    chk("unmapped error", rerr, 1);
    chk("unmapped data", rdv, 0);
  endtask
  // Byte data, 16-bit polynomial, MSb first, completion event.
  task automatic s_crc16;
    run_crc(5'h0f, 5'h07, 32'h1021, 0, 1, 2, 32'h31, 32'h1);
  endtask
  // Same polynomial LSb first with the last-pop event.
  task automatic s_lsb;
    run_crc(5'h0f, 5'h07, 32'h1021, 1, 0, 3, 32'h5a, 32'h11);
  endtask
  // Full 32-bit order with idle requested but no halt selected; one word beyond depth dropped.
  task automatic s_crc32;
    idle_req <= 1;
    run_crc(5'h1f, 5'h1f, 32'h04c11db7, 0, 1, 5, 32'h12345678, 32'h11111111);
    idle_req <= 0;
  endtask
  // Mid and narrow widths: depths eight and sixteen, upper bits ignored.
  task automatic s_widths;
    run_crc(5'h0b, 5'h0b, 32'h080f, 0, 1, 9, 32'hf3a5, 32'h0123);
    run_crc(5'h07, 5'h04, 32'h07, 0, 1, 17, 32'hc5, 32'h3);
  endtask
  // Turning the module off empties the FIFO and clears the result.
  task automatic s_off;
    apb(1, `PCG_OFF_DATA_LO, 32'h5);
    apb(1, `PCG_OFF_CTRL, 0);
    apb(0, `PCG_OFF_CTRL, 0);
    chk("count when off", rdv[12:6], 1);
    apb(0, `PCG_OFF_RES_LO, 0);
    chk("result when off", rdv, 0);
  endtask
  // Idle halt holds the engine until idle ends.
  task automatic s_idle;
    apb(1, `PCG_OFF_CTRL, 32'h8000);
    apb(1, `PCG_OFF_DATA_LO, 32'h3);
    idle_req <= 1;
    apb(1, `PCG_OFF_CTRL, 32'ha010);
    repeat (40) @(posedge pclk);
    apb(0, `PCG_OFF_CTRL, 0);
    chk("halted in idle", {rdv[12:8], rdv[4]}, 3);
    idle_req <= 0;
    wait_done();
    chk("resumed after idle", rdv[12:8], 0);
  endtask
  // Partial strobes on a 24-bit width: only the lane holding the MSb completes a word.
  task automatic s_strobe;
    apb(1, `PCG_OFF_CFG, 32'h1700);
    apb(1, `PCG_OFF_DATA_LO, 32'h1234);
    pstrb <= 4'h2;
    apb(1, `PCG_OFF_DATA_HI, 32'h5600);
    apb(0, `PCG_OFF_CTRL, 0);
    chk("count after upper lane", rdv[12:8], 0);
    pstrb <= 4'h1;
    apb(1, `PCG_OFF_DATA_HI, 32'h0078);
    pstrb <= 4'hf;
    apb(0, `PCG_OFF_CTRL, 0);
    chk("count after msb lane", rdv[12:8], 1);
    apb(0, `PCG_OFF_DATA_HI, 0);
    chk("staged high half", rdv, 32'h5678);
    apb(1, `PCG_OFF_CTRL, 0);
    apb(0, `PCG_OFF_DATA_HI, 0);
    chk("high half when off", rdv, 0);
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    s_reset();
    s_crc16();
    s_lsb();
    s_crc32();
    s_widths();
    s_off();
    s_idle();
    s_strobe();
    complete_run();
  end
endmodule
